/* rtl/ccp_pwm_pkg.sv */
// Register map, field layout and timing constants of the PWM output unit
package ccp_pwm_pkg;

   // Bus widths
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [3:0] ADDR_UNIT1_CONTROL   = 4'h0;
   localparam logic [3:0] ADDR_UNIT1_DUTY_HIGH = 4'h1;
   localparam logic [3:0] ADDR_UNIT1_SHADOW    = 4'h2;
   localparam logic [3:0] ADDR_UNIT2_CONTROL   = 4'h3;
   localparam logic [3:0] ADDR_UNIT2_DUTY_HIGH = 4'h4;
   localparam logic [3:0] ADDR_UNIT2_SHADOW    = 4'h5;
   localparam logic [3:0] ADDR_PERIOD          = 4'h6;
   localparam logic [3:0] ADDR_TIMER2_CONTROL  = 4'h7;
   localparam logic [3:0] ADDR_TIMER2_COUNT    = 4'h8;
   localparam logic [3:0] ADDR_PIN_SELECT      = 4'h9;
   localparam logic [3:0] ADDR_PORT_LATCH      = 4'ha;
   localparam logic [3:0] ADDR_PIN_DIRECTION   = 4'hb;

   // Unit control fields: duty low bits 5:4, mode select 3:0
   localparam int         DUTY_LOW_LSB   = 4;
   localparam int         MODE_PWM_LSB   = 2;
   localparam logic [1:0] MODE_PWM_MSBS  = 2'b11;
   localparam logic [7:0] CONTROL_MASK   = 8'h3f;

   // Timer control fields: postscale 6:3, enable 2, prescale 1:0
   localparam int         TIMER_ON_BIT   = 2;
   localparam logic [7:0] TIMER_CTL_MASK = 8'h7f;

   // Pin select, port latch and direction bits
   localparam int         PIN_SELECT_BIT = 0;
   localparam logic [7:0] PIN_SELECT_MASK = 8'h01;
   localparam int         PIN_UNIT1_BIT  = 0;
   localparam int         PIN_ALT_A_BIT  = 1;
   localparam int         PIN_ALT_B_BIT  = 2;
   localparam logic [7:0] PIN_MASK       = 8'h07;

   // Reset values
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'h07;

   // Timer prescale settings
   typedef enum logic [1:0] {
      PRE_1   = 2'b00,
      PRE_4   = 2'b01,
      PRE_16  = 2'b10,
      PRE_16B = 2'b11
   } prescale_e;

   // Oscillator periods per timer step at 1:1, and prescaler counter width
   localparam int         TOSC_PER_STEP = 4;
   localparam int         PRE_CNT_W     = 6;
   localparam logic [5:0] PRE_LAST_1    = 6'(TOSC_PER_STEP * 1 - 1);
   localparam logic [5:0] PRE_LAST_4    = 6'(TOSC_PER_STEP * 4 - 1);
   localparam logic [5:0] PRE_LAST_16   = 6'(TOSC_PER_STEP * 16 - 1);

endpackage

/* rtl/ccp_pwm_output_unit.sv */
// Two-unit PWM generator on an 8-bit timer with register port and pin muxing
module ccp_pwm_output_unit
   import ccp_pwm_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWriteData,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [DATA_W-1:0] regReadData,
   input  wire logic              sleep,
   output logic                   pwmOutputPin1,
   output logic                   pwmOutputPin1Oe,
   output logic                   ccp2PinAltA,
   output logic                   ccp2PinAltAOe,
   output logic                   ccp2PinAltB,
   output logic                   ccp2PinAltBOe
);

   localparam logic [3:0] CTRL_ADDR [2]   = '{ADDR_UNIT1_CONTROL, ADDR_UNIT2_CONTROL};
   localparam logic [3:0] DUTY_ADDR [2]   = '{ADDR_UNIT1_DUTY_HIGH, ADDR_UNIT2_DUTY_HIGH};
   localparam logic [3:0] SHADOW_ADDR [2] = '{ADDR_UNIT1_SHADOW, ADDR_UNIT2_SHADOW};

   logic [7:0]           control [2];
   logic [7:0]           dutyHigh [2];
   logic [7:0]           shadowHigh [2];
   logic [1:0]           shadowLow [2];
   logic [9:0]           dutyVal [2];
   logic [9:0]           shadowVal [2];
   logic [1:0]           pwmMode;
   logic [1:0]           level;
   logic [1:0]           wave;
   logic [7:0]           period;
   logic [7:0]           timerCtl;
   logic [7:0]           timerCount;
   logic [7:0]           pinSelect;
   logic [7:0]           portLatch;
   logic [7:0]           direction;
   logic [PRE_CNT_W-1:0] preCnt;
   logic [PRE_CNT_W-1:0] preLast;
   logic [1:0]           fineBits;
   logic [9:0]           timeBase;
   prescale_e            prescaleSel;
   logic                 timerOn;
   logic                 increment;
   logic                 periodEnd;
   logic                 swWriteCount;
   logic [7:0]           next_readData;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // Prescale decode; postscale bits 6:3 are stored but never reach the PWM
   assign prescaleSel  = prescale_e'(timerCtl[1:0]);
   assign timerOn      = timerCtl[TIMER_ON_BIT];
   assign swWriteCount = regWrite && (regAddr == ADDR_TIMER2_COUNT);

   always_comb
   begin
      case (prescaleSel)
         PRE_1:
         begin
            preLast  = PRE_LAST_1;
            fineBits = preCnt[1:0];
         end
         PRE_4:
         begin
            preLast  = PRE_LAST_4;
            fineBits = preCnt[3:2];
         end
         default:
         begin
            preLast  = PRE_LAST_16;
            fineBits = preCnt[5:4];
         end
      endcase
   end

   // One timer step per four oscillator periods times prescale, none in sleep
   assign increment = timerOn && !sleep && (preCnt == preLast);
   assign periodEnd = increment && (timerCount == period);
   assign timeBase  = {timerCount, fineBits};

   // Prescaler counter; cleared while the timer is off so a restart is clean
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         preCnt <= '0;
      else if (!timerOn)
         preCnt <= '0;
      else if (!sleep)
         preCnt <= increment ? '0 : preCnt + 6'h01;
   end

   // Timer count; a software write wins over the step
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         timerCount <= REG_RESET;
      else if (swWriteCount)
         timerCount <= regWriteData;
      else if (increment)
         timerCount <= periodEnd ? 8'h00 : timerCount + 8'h01;
   end

   // Shared configuration registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         period    <= REG_RESET;
         timerCtl  <= REG_RESET;
         pinSelect <= REG_RESET;
         portLatch <= REG_RESET;
         direction <= DIRECTION_RESET;
      end
      else if (regWrite)
      begin
         case (regAddr)
            ADDR_PERIOD:         period    <= regWriteData;
            ADDR_TIMER2_CONTROL: timerCtl  <= regWriteData & TIMER_CTL_MASK;
            ADDR_PIN_SELECT:     pinSelect <= regWriteData & PIN_SELECT_MASK;
            ADDR_PORT_LATCH:     portLatch <= regWriteData & PIN_MASK;
            ADDR_PIN_DIRECTION:  direction <= regWriteData & PIN_MASK;
            default:             period    <= period;
         endcase
      end
   end

   // Per-unit registers, duty buffering and waveform level
   for (genvar u = 0; u < 2; u++)
   begin : g_unit
      assign pwmMode[u]   = control[u][3:MODE_PWM_LSB] == MODE_PWM_MSBS;
      assign dutyVal[u]   = {dutyHigh[u], control[u][DUTY_LOW_LSB +: 2]};
      assign shadowVal[u] = {shadowHigh[u], shadowLow[u]};

      // Control and programmed duty are writable at any moment
      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            control[u]  <= REG_RESET;
            dutyHigh[u] <= REG_RESET;
         end
         else if (regWrite && regAddr == CTRL_ADDR[u])
            control[u] <= regWriteData & CONTROL_MASK;
         else if (regWrite && regAddr == DUTY_ADDR[u])
            dutyHigh[u] <= regWriteData;
      end

      // In PWM mode shadow loads only at period end, so a mid-period write cannot glitch
      always_ff @(posedge clk_sys)
      begin
         if (rst)
         begin
            shadowHigh[u] <= REG_RESET;
            shadowLow[u]  <= 2'b00;
         end
         else if (periodEnd && pwmMode[u])
         begin
            shadowHigh[u] <= dutyVal[u][9:2];
            shadowLow[u]  <= dutyVal[u][1:0];
         end
         else if (regWrite && regAddr == SHADOW_ADDR[u] && !pwmMode[u])
            shadowHigh[u] <= regWriteData;
      end

      // Set at period start, clear on time-base match; no match if too long
      always_ff @(posedge clk_sys)
      begin
         if (rst)
            level[u] <= 1'b0;
         else if (!pwmMode[u])
            level[u] <= 1'b0;
         else if (sleep)
            level[u] <= level[u];
         else if (periodEnd)
            level[u] <= dutyVal[u] != 10'h000;
         else if (timeBase == shadowVal[u])
            level[u] <= 1'b0;
      end

      // Waveform drops in the match cycle itself, since level lags by one edge;
      // without this a pulse runs one clock long and a last-step match is lost
      assign wave[u] = level[u] && (timeBase != shadowVal[u]);

      sequence loadSeq;
         periodEnd && pwmMode[u];
      endsequence

      shadow_load_a : assert property (loadSeq |=> shadowVal[u] == $past(dutyVal[u]))
         else $error("shadow duty not loaded at period end");
      pin_set_a : assert property (loadSeq ##0 dutyVal[u] != 10'h000
            |=> !pwmMode[u] || level[u])
         else $error("pin not set at period start");
      zero_duty_a : assert property (periodEnd && dutyVal[u] == 10'h000 |=> !level[u])
         else $error("pin set with zero duty");
      duty_clear_a : assert property (pwmMode[u] && !sleep && !periodEnd
            && timeBase == shadowVal[u] |=> !level[u])
         else $error("pin not cleared on duty match");
      sleep_hold_a : assert property (sleep && pwmMode[u]
            && !(regWrite && regAddr == CTRL_ADDR[u]) |=> $stable(level[u]))
         else $error("waveform level moved in sleep");
      shadow_ro_a : assert property (pwmMode[u] && !periodEnd && regWrite
            && regAddr == SHADOW_ADDR[u] |=> $stable(shadowVal[u]))
         else $error("shadow duty written in pwm mode");
   end

   // Pins: PWM level replaces the port latch on pin 1 and on the selected unit 2 pin while in PWM mode
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pwmOutputPin1 <= 1'b0;
         ccp2PinAltA   <= 1'b0;
         ccp2PinAltB   <= 1'b0;
      end
      else
      begin
         pwmOutputPin1 <= pwmMode[0] ? wave[0] : portLatch[PIN_UNIT1_BIT];
         ccp2PinAltA   <= (pwmMode[1] && !pinSelect[PIN_SELECT_BIT]) ? wave[1]
                          : portLatch[PIN_ALT_A_BIT];
         ccp2PinAltB   <= (pwmMode[1] && pinSelect[PIN_SELECT_BIT]) ? wave[1]
                          : portLatch[PIN_ALT_B_BIT];
      end
   end

   // Drivers follow direction bits; reset leaves every pin an input
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pwmOutputPin1Oe <= 1'b0;
         ccp2PinAltAOe   <= 1'b0;
         ccp2PinAltBOe   <= 1'b0;
      end
      else
      begin
         pwmOutputPin1Oe <= !direction[PIN_UNIT1_BIT];
         ccp2PinAltAOe   <= !direction[PIN_ALT_A_BIT];
         ccp2PinAltBOe   <= !direction[PIN_ALT_B_BIT];
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb
   begin
      case (regAddr)
         ADDR_UNIT1_CONTROL:   next_readData = control[0];
         ADDR_UNIT1_DUTY_HIGH: next_readData = dutyHigh[0];
         ADDR_UNIT1_SHADOW:    next_readData = shadowHigh[0];
         ADDR_UNIT2_CONTROL:   next_readData = control[1];
         ADDR_UNIT2_DUTY_HIGH: next_readData = dutyHigh[1];
         ADDR_UNIT2_SHADOW:    next_readData = shadowHigh[1];
         ADDR_PERIOD:          next_readData = period;
         ADDR_TIMER2_CONTROL:  next_readData = timerCtl;
         ADDR_TIMER2_COUNT:    next_readData = timerCount;
         ADDR_PIN_SELECT:      next_readData = pinSelect;
         ADDR_PORT_LATCH:      next_readData = portLatch;
         ADDR_PIN_DIRECTION:   next_readData = direction;
         default:              next_readData = 8'h00;
      endcase
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         regReadData <= 8'h00;
      else
         regReadData <= regRead ? next_readData : 8'h00;
   end

   sequence wrapSeq;
      periodEnd && !swWriteCount;
   endsequence

   period_wrap_a : assert property (wrapSeq |=> timerCount == 8'h00)
      else $error("timer not cleared after period match");
   count_step_a : assert property (increment && !periodEnd && !swWriteCount
         |=> timerCount == $past(timerCount) + 8'h01)
      else $error("timer did not step by one");
   prescale_rate_a : assert property (increment && prescaleSel == PRE_1
         |=> !increment [*3])
      else $error("timer stepped faster than four clocks");
   sleep_timer_a : assert property (sleep && !swWriteCount |=> $stable(timerCount))
      else $error("timer moved in sleep");
   pin_release_a : assert property (!pwmMode[0]
         |=> pwmOutputPin1 == $past(portLatch[PIN_UNIT1_BIT]))
      else $error("pin not returned to port latch");
   pin_follow_a : assert property (pwmMode[0] |=> pwmOutputPin1 == $past(wave[0]))
      else $error("pin does not follow waveform");
   pin_clear_a : assert property (pwmMode[0] && timeBase == shadowVal[0]
         |=> !pwmOutputPin1)
      else $error("pin high after duty match");
   alt_route_a : assert property (pwmMode[1] && pinSelect[PIN_SELECT_BIT]
         |=> ccp2PinAltB == $past(wave[1])
             && ccp2PinAltA == $past(portLatch[PIN_ALT_A_BIT]))
      else $error("unit two routed to wrong pin");

endmodule

/* test/tb.sv */
// Self-checking bench for the two-unit PWM output block
module tb
   import ccp_pwm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic                clk_sys = 1'b0;
   logic                rst = 1'b1;
   logic [ADDR_W-1:0]   regAddr = '0;
   logic [DATA_W-1:0]   regWriteData = '0;
   logic                regWrite = 1'b0;
   logic                regRead = 1'b0;
   logic [DATA_W-1:0]   regReadData;
   logic                sleep = 1'b0;
   logic                pwmOutputPin1;
   logic                pwmOutputPin1Oe;
   logic                ccp2PinAltA;
   logic                ccp2PinAltAOe;
   logic                ccp2PinAltB;
   logic                ccp2PinAltBOe;
   int                  miscompares = 0;
   int                  checkCount = 0;
   logic [7:0]          rv;
   logic [7:0]          rv2;
   logic [15:0]         highs;
   logic [15:0]         rises;
   int                  plen;
   int                  hw;
   int                  pv;

   // Case table: period, prescale code, 10-bit duty
   logic [7:0] cPer [7] = '{8'h00, 8'h03, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01};
   logic [1:0] cPre [7] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00, 2'b00, 2'b00};
   logic [9:0] cDuty [7] = '{10'h002, 10'h00d, 10'h005, 10'h003, 10'h000, 10'h008, 10'h007};
   logic [7:0] mAddr [6] = '{8'h00, 8'h07, 8'h09, 8'h0a, 8'h0b, 8'h03};
   logic [7:0] mExp [6] = '{8'h3f, 8'h7f, 8'h01, 8'h07, 8'h07, 8'h3f};

   // 100 ns period clock
   always #50 clk_sys = ~clk_sys;

   ccp_pwm_output_unit dut (
      .clk_sys         (clk_sys),
      .rst             (rst),
      .regAddr         (regAddr),
      .regWriteData    (regWriteData),
      .regWrite        (regWrite),
      .regRead         (regRead),
      .regReadData     (regReadData),
      .sleep           (sleep),
      .pwmOutputPin1   (pwmOutputPin1),
      .pwmOutputPin1Oe (pwmOutputPin1Oe),
      .ccp2PinAltA     (ccp2PinAltA),
      .ccp2PinAltAOe   (ccp2PinAltAOe),
      .ccp2PinAltB     (ccp2PinAltB),
      .ccp2PinAltBOe   (ccp2PinAltBOe)
   );

   task automatic conclude();
      if (miscompares == 0 && checkCount > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checkCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr      <= a;
      regWriteData <= d;
      regWrite     <= 1'b1;
      @(posedge clk_sys);
      regWrite     <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      @(negedge clk_sys);
      d = regReadData;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Count high cycles and rising edges of the unit 1 pin
   task automatic measure(input int n, output logic [15:0] h, output logic [15:0] r);
      logic prev;
      h = '0;
      r = '0;
      @(negedge clk_sys);
      prev = pwmOutputPin1;
      repeat (n)
      begin
         @(negedge clk_sys);
         if (pwmOutputPin1 === 1'b1)
            h++;
         if (pwmOutputPin1 === 1'b1 && prev === 1'b0)
            r++;
         prev = pwmOutputPin1;
      end
   endtask

   // Bounded wait for a period start on the unit 1 pin
   task automatic waitRise(input int bound);
      int i;
      for (i = 0; i < bound; i++)
      begin
         @(negedge clk_sys);
         if (pwmOutputPin1 === 1'b0)
            break;
      end
      for (i = 0; i < bound; i++)
      begin
         @(negedge clk_sys);
         if (pwmOutputPin1 === 1'b1)
            break;
      end
      if (i == bound)
      begin
         miscompares++;
         conclude();
      end
   endtask

   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      // Reset values, unmapped offset included
      for (int a = 0; a < 13; a++)
      begin
         rd(4'(a), rv);
         chk("reset value", (a == 11) ? 16'(DIRECTION_RESET) : 16'h0000, rv);
      end
      chk("pin oe", 16'h0000, pwmOutputPin1Oe);
      // Implemented bits only
      for (int i = 0; i < 6; i++)
      begin
         wr(mAddr[i][3:0], 8'hff);
         rd(mAddr[i][3:0], rv);
         chk("mask", mExp[i], rv);
      end
      wr(4'hc, 8'hff);
      rd(4'hc, rv);
      chk("unmapped", 16'h0000, rv);
      wr(ADDR_UNIT1_CONTROL, 8'h00);
      wr(ADDR_UNIT2_CONTROL, 8'h00);
      wr(ADDR_TIMER2_CONTROL, 8'h00);
      wr(ADDR_PIN_DIRECTION, 8'h00);
      idle(3);
      chk("latch pin", 16'h0001, pwmOutputPin1);
      chk("latch oe", 16'h0001, pwmOutputPin1Oe);
      wr(ADDR_PORT_LATCH, 8'h00);
      // Period and pulse width over prescales and duty boundaries
      for (int c = 0; c < 7; c++)
      begin
         pv = (cPre[c] == 2'b00) ? 1 : (cPre[c] == 2'b01) ? 4 : 16;
         plen = (int'(cPer[c]) + 1) * TOSC_PER_STEP * pv;
         hw = int'(cDuty[c]) * pv;
         wr(ADDR_TIMER2_CONTROL, 8'h00);
         wr(ADDR_TIMER2_COUNT, 8'h00);
         wr(ADDR_PERIOD, cPer[c]);
         wr(ADDR_UNIT1_DUTY_HIGH, cDuty[c][9:2]);
         wr(ADDR_UNIT1_CONTROL, {2'b00, cDuty[c][1:0], 4'hc});
         // Postscale bits set to show they do not matter
         wr(ADDR_TIMER2_CONTROL, {6'b011111, cPre[c]});
         idle(2 * plen);
         measure(4 * plen, highs, rises);
         chk("high cycles", 16'((hw >= plen) ? 4 * plen : 4 * hw), highs);
         chk("period starts", (cDuty[c] != 0 && hw < plen) ? 16'd4 : 16'd0, rises);
      end
      // Double buffering of the duty value
      wr(ADDR_TIMER2_CONTROL, 8'h00);
      wr(ADDR_TIMER2_COUNT, 8'h00);
      wr(ADDR_PERIOD, 8'hff);
      wr(ADDR_UNIT1_DUTY_HIGH, 8'h10);
      wr(ADDR_UNIT1_CONTROL, 8'h0c);
      wr(ADDR_TIMER2_CONTROL, 8'h04);
      waitRise(1100);
      rd(ADDR_UNIT1_SHADOW, rv);
      chk("shadow load", 16'h0010, rv);
      wr(ADDR_UNIT1_DUTY_HIGH, 8'h40);
      wr(ADDR_UNIT1_SHADOW, 8'h99);
      rd(ADDR_UNIT1_SHADOW, rv);
      chk("shadow held", 16'h0010, rv);
      waitRise(1100);
      rd(ADDR_UNIT1_SHADOW, rv);
      chk("shadow new", 16'h0040, rv);
      measure(1020, highs, rises);
      chk("new width", 16'd252, highs);
      // Sleep freezes timer and pin level
      waitRise(1100);
      @(posedge clk_sys);
      sleep <= 1'b1;
      rd(ADDR_TIMER2_COUNT, rv);
      measure(300, highs, rises);
      rd(ADDR_TIMER2_COUNT, rv2);
      chk("sleep count", rv, rv2);
      chk("sleep level", 16'd300, highs);
      @(posedge clk_sys);
      sleep <= 1'b0;
      // Unit 2 routing between alternate pins; restart count so matches follow
      wr(ADDR_PERIOD, 8'h00);
      wr(ADDR_TIMER2_COUNT, 8'h00);
      wr(ADDR_UNIT2_DUTY_HIGH, 8'hff);
      wr(ADDR_UNIT2_CONTROL, 8'h3c);
      wr(ADDR_PIN_SELECT, 8'h00);
      idle(20);
      chk("alt a pwm", 16'h0001, ccp2PinAltA);
      chk("alt b latch", 16'h0000, ccp2PinAltB);
      chk("alt oe", 16'h0003, {ccp2PinAltBOe, ccp2PinAltAOe});
      wr(ADDR_PORT_LATCH, 8'h02);
      wr(ADDR_PIN_SELECT, 8'h01);
      idle(20);
      chk("alt pins sel", 16'h0003, {ccp2PinAltB, ccp2PinAltA});
      wr(ADDR_UNIT2_CONTROL, 8'h00);
      idle(3);
      chk("alt released", 16'h0001, {ccp2PinAltB, ccp2PinAltA});
      // Mid-run reset
      wr(ADDR_UNIT2_CONTROL, 8'h3c);
      @(posedge clk_sys);
      rst <= 1'b1;
      idle(2);
      rst <= 1'b0;
      rd(ADDR_UNIT1_CONTROL, rv);
      chk("reset control", 16'h0000, rv);
      rd(ADDR_UNIT2_DUTY_HIGH, rv);
      chk("reset duty", 16'h0000, rv);
      rd(ADDR_UNIT1_SHADOW, rv);
      chk("reset shadow", 16'h0000, rv);
      chk("reset pins", 16'h0000, {ccp2PinAltB, ccp2PinAltA, pwmOutputPin1});
      chk("reset oe", 16'h0000, {ccp2PinAltBOe, ccp2PinAltAOe, pwmOutputPin1Oe});
      conclude();
   end
endmodule
